// file: rtl/amr_device.sv
// Drive end: enters and leaves active mode and handles the exceptions.
// Assumes the host keeps to the link behaviour; pins are asynchronous.
//
// What this block and the host end do
// - Old bus speed: host holds, then waits
// - Interpolating: host drops target or idles
// - Old bus positioning: host sends hold
// - Host resumes only after indicator drops
// - New bus speed: host sets cancel bit
// - New bus positioning: host sets cancel bit
// - System reset ends mode, restarts servo
// - Parameter recalculation ends active mode
// - New bus config with servo on: warn
// - Overtravel replaces internal deceleration
// - After overtravel stop, wait hold time
// - Servo-on cleared ends active mode
// - Zero clamp off during active mode
// - Release needs request, hold time, limits
`timescale 1ns/1ns
module amr_device #(
    parameter int CYC_PER_UNIT = amr_pkg::AMR_CYC_PER_UNIT,
    parameter int HOLD_W       = amr_pkg::AMR_HOLD_W
) (
    input  wire logic              REF_CLK,
    input  wire logic              RESET_N,
    amr_link_if.dev                LINK,
    input  wire logic              SAFETY_REQ,
    input  wire logic              OVERTRAVEL,
    input  wire logic              MOTOR_STOPPED,
    input  wire logic              ZERO_CLAMP_REQ,
    input  wire logic              ACTIVE_ENABLE,
    input  wire amr_pkg::amr_ref_t REF_PATH,
    input  wire logic              POS_MODE,
    input  wire logic              POS_ERR_OK,
    input  wire logic              SPEED_REF_OK,
    input  wire logic [HOLD_W-1:0] HOLD_TIME,
    input  wire logic              SYS_RESET_REQ,
    input  wire logic              PARAM_RECALC,
    output logic                   ACTIVE_MODE,
    output logic                   INTERNAL_DECEL,
    output logic                   OT_DECEL,
    output logic                   SERVO_RESTART,
    output logic                   RECALC_DONE,
    output logic                   ZERO_CLAMP
);
    import amr_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            // Safety request idles ON; resetting its stages low would fake an entry
            sync_a <= 4'h1;
            sync_b <= 4'h1;
        end else begin
            sync_a <= {ZERO_CLAMP_REQ, MOTOR_STOPPED, OVERTRAVEL, SAFETY_REQ};
            sync_b <= sync_a;
        end
    end

    logic safety_on;
    logic ot_in;
    logic stopped_in;
    logic zc_in;
    assign safety_on  = sync_b[0];
    assign ot_in      = sync_b[1];
    assign stopped_in = sync_b[2];
    assign zc_in      = sync_b[3];

    // ----------------------------------------
    // Mode state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ACTIVE,
        ST_OT_STOP,
        ST_OT_HOLD
    } amr_state_t;

    amr_state_t state;
    amr_state_t next_state;

    logic config_req;
    logic config_refused;
    logic recalc_now;
    logic end_now;
    logic hold_elapsed;
    logic limits_ok;
    logic release_ok;
    logic restart_hold;

    // A config on the newer bus with servo on is refused outright
    assign config_req     = LINK.cmd_valid && (LINK.cmd == CMD_CONFIG);
    assign config_refused = config_req && (REF_PATH == REF_BUS_NEW) && LINK.servo_on;
    assign recalc_now     = PARAM_RECALC || (config_req && !config_refused);

    // Any of these drops active mode at once, whatever the phase
    assign end_now = SYS_RESET_REQ ||
                     recalc_now ||
                     !LINK.servo_on;

    assign limits_ok  = POS_MODE ? POS_ERR_OK : SPEED_REF_OK;
    assign release_ok = safety_on && hold_elapsed && limits_ok;

    always_comb begin
        next_state = state;
        case (state)
            ST_NORMAL: begin
                if (!safety_on && ACTIVE_ENABLE && LINK.servo_on && !end_now) begin
                    next_state = ot_in ? ST_OT_STOP : ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (end_now) begin
                    next_state = ST_NORMAL;
                end else if (ot_in) begin
                    next_state = ST_OT_STOP;
                end else if (release_ok) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_OT_STOP: begin
                if (end_now) begin
                    next_state = ST_NORMAL;
                end else if (stopped_in) begin
                    next_state = ST_OT_HOLD;
                end
            end
            ST_OT_HOLD: begin
                if (end_now) begin
                    next_state = ST_NORMAL;
                end else if (release_ok) begin
                    next_state = ST_NORMAL;
                end
            end
            default: next_state = ST_NORMAL;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Hold timer
    // ----------------------------------------
    // Counts whole units since entry, restarted once the overtravel
    // stop completes; saturates so a long wait never wraps to zero.
    logic [$clog2(CYC_PER_UNIT+1)-1:0] prescale;
    logic [HOLD_W-1:0]                 hold_units;
    logic                              unit_tick;

    assign unit_tick    = (prescale == ($clog2(CYC_PER_UNIT+1))'(CYC_PER_UNIT - 1));
    assign restart_hold = (state == ST_NORMAL) ||
                          ((state == ST_OT_STOP) && stopped_in);
    assign hold_elapsed = (hold_units > HOLD_TIME);

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prescale <= '0;
        end else if (restart_hold || unit_tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_units <= AMR_HOLD_RESET;
        end else if (restart_hold) begin
            hold_units <= AMR_HOLD_RESET;
        end else if (unit_tick && (hold_units != '1)) begin
            hold_units <= hold_units + 1'b1;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic active_next;
    assign active_next = (next_state != ST_NORMAL);

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACTIVE_MODE      <= 1'b0;
            LINK.active_mode <= 1'b0;
            INTERNAL_DECEL   <= 1'b0;
            OT_DECEL         <= 1'b0;
        end else begin
            ACTIVE_MODE      <= active_next;
            LINK.active_mode <= active_next;
            INTERNAL_DECEL   <= (next_state == ST_ACTIVE);
            OT_DECEL         <= (next_state == ST_OT_STOP);
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SERVO_RESTART    <= 1'b0;
            RECALC_DONE      <= 1'b0;
            LINK.cmd_warning <= 1'b0;
        end else begin
            SERVO_RESTART    <= SYS_RESET_REQ;
            RECALC_DONE      <= recalc_now;
            LINK.cmd_warning <= config_refused;
        end
    end

    // Clamp only exists on the analog path and never while active
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ZERO_CLAMP <= 1'b0;
        end else begin
            ZERO_CLAMP <= zc_in && (REF_PATH == REF_ANALOG) && !active_next;
        end
    end

endmodule

// file: rtl/amr_pkg.sv
// Shared constants and types for the active mode return control link.
// Assumes one 20 MHz clock shared by both ends of the link.
package amr_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int AMR_CLK_PERIOD_NS  = 50;
    localparam int AMR_HOLD_UNIT_NS   = 1_000_000;
    localparam int AMR_CYC_PER_UNIT   = (AMR_HOLD_UNIT_NS + AMR_CLK_PERIOD_NS - 1) / AMR_CLK_PERIOD_NS;
    localparam int AMR_HOLD_W         = 16;
    localparam logic [15:0] AMR_HOLD_RESET = 16'h0000;

    // ----------------------------------------
    // Link command codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP     = 4'h0,
        CMD_HOLD    = 4'h1,
        CMD_STATUS_MONITOR_COMMAND    = 4'h2,
        CMD_INTERP  = 4'h3,
        CMD_POSITIONING_COMMAND  = 4'h4,
        CMD_FEED    = 4'h5,
        CMD_EXPOS   = 4'h6,
        CMD_EXFEED  = 4'h7,
        CMD_HOMING  = 4'h8,
        CMD_VELOCITY_CONTROL_COMMAND = 4'h9,
        CMD_CONFIG  = 4'hA
    } amr_cmd_t;

    // Reference path of the drive
    typedef enum logic [1:0] {
        REF_ANALOG  = 2'h0,
        REF_BUS_OLD = 2'h1,
        REF_BUS_NEW = 2'h2
    } amr_ref_t;

    // Positioning commands that need a hold or cancel on entry
    function automatic logic amr_is_positioning_command(input amr_cmd_t c);
        return (c == CMD_POSITIONING_COMMAND) || (c == CMD_FEED) || (c == CMD_EXPOS) ||
               (c == CMD_EXFEED) || (c == CMD_HOMING);
    endfunction

endpackage

// file: rtl/amr_link_if.sv
// Command link between the host motion controller and the drive.
// Assumes both ends share one clock; all signals are plain levels or pulses.
`timescale 1ns/1ns
interface amr_link_if;
    import amr_pkg::*;

    logic     cmd_valid;
    amr_cmd_t cmd;
    logic     cancel;
    logic     target_position_valid;
    logic     servo_on;
    logic     active_mode;
    logic     cmd_warning;

    modport dev (
        input  cmd_valid,
        input  cmd,
        input  cancel,
        input  target_position_valid,
        input  servo_on,
        output active_mode,
        output cmd_warning
    );

    modport host (
        output cmd_valid,
        output cmd,
        output cancel,
        output target_position_valid,
        output servo_on,
        input  active_mode,
        input  cmd_warning
    );
endinterface

// file: rtl/amr_host.sv
// Host motion controller end: reacts to the active mode indicator.
// Assumes the drive end on the same clock; user requests are same-domain.
`timescale 1ns/1ns
module amr_host (
    input  wire logic               REF_CLK,
    input  wire logic               RESET_N,
    amr_link_if.host                LINK,
    input  wire amr_pkg::amr_ref_t  REF_PATH,
    input  wire logic               POS_MODE,
    input  wire logic               SERVO_ON_REQ,
    input  wire logic               USER_CMD_VALID,
    input  wire amr_pkg::amr_cmd_t  USER_CMD,
    output logic                    USER_CMD_TAKEN,
    output logic                    STANDBY,
    output logic                    WARNING_SEEN
);
    import amr_pkg::*;

    // ----------------------------------------
    // Reaction state
    // ----------------------------------------
    typedef enum logic [1:0] {
        HS_RUN,
        HS_REACT,
        HS_WAIT
    } amr_hstate_t;

    amr_hstate_t hstate;
    amr_cmd_t    running;
    logic        act_prev;
    logic        act_rise;

    assign act_rise = LINK.active_mode && !act_prev;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_prev <= 1'b0;
            hstate   <= HS_RUN;
        end else begin
            act_prev <= LINK.active_mode;
            case (hstate)
                HS_RUN:   hstate <= act_rise ? HS_REACT : HS_RUN;
                HS_REACT: hstate <= HS_WAIT;
                // Normal traffic resumes only once the indicator drops
                HS_WAIT:  hstate <= LINK.active_mode ? HS_WAIT : HS_RUN;
                default:  hstate <= HS_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Command issue
    // ----------------------------------------
    logic user_go;
    assign user_go = USER_CMD_VALID && (hstate == HS_RUN) && !act_rise;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            running <= CMD_NOP;
        end else if (user_go) begin
            running <= USER_CMD;
        end else if (hstate == HS_REACT) begin
            running <= CMD_NOP;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LINK.cmd_valid  <= 1'b0;
            LINK.cmd        <= CMD_NOP;
            LINK.cancel     <= 1'b0;
            LINK.target_position_valid <= 1'b0;
            USER_CMD_TAKEN  <= 1'b0;
        end else begin
            LINK.cmd_valid <= 1'b0;
            LINK.cancel    <= 1'b0;
            USER_CMD_TAKEN <= user_go;
            if (user_go) begin
                LINK.cmd_valid  <= 1'b1;
                LINK.cmd        <= USER_CMD;
                LINK.target_position_valid <= (USER_CMD == CMD_INTERP);
            end else if (hstate == HS_REACT) begin
                if (POS_MODE && (running == CMD_INTERP)) begin
                    LINK.target_position_valid <= 1'b0;
                    LINK.cmd_valid  <= 1'b1;
                    LINK.cmd        <= CMD_NOP;
                end else if (REF_PATH == REF_BUS_NEW) begin
                    if (!POS_MODE && (running == CMD_VELOCITY_CONTROL_COMMAND)) begin
                        LINK.cancel <= 1'b1;
                    end else if (POS_MODE && amr_is_positioning_command(running)) begin
                        LINK.cancel <= 1'b1;
                    end
                end else if (REF_PATH == REF_BUS_OLD) begin
                    if (!POS_MODE || amr_is_positioning_command(running)) begin
                        LINK.cmd_valid <= 1'b1;
                        LINK.cmd       <= CMD_HOLD;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Status to the user
    // ----------------------------------------
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LINK.servo_on <= 1'b0;
            STANDBY       <= 1'b0;
            WARNING_SEEN  <= 1'b0;
        end else begin
            LINK.servo_on <= SERVO_ON_REQ;
            STANDBY       <= (hstate != HS_RUN) || act_rise;
            // Sticky until the next accepted command
            WARNING_SEEN  <= LINK.cmd_warning || (WARNING_SEEN && !user_go);
        end
    end

endmodule

// file: bench/amr_link_properties.sv
// Checker for the command link between host and drive ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module amr_link_properties
    import amr_pkg::*;
(
    input wire logic     REF_CLK,
    input wire logic     RESET_N,
    input wire logic     cmd_valid,
    input wire amr_cmd_t cmd,
    input wire logic     cancel,
    input wire logic     target_position_valid,
    input wire logic     servo_on,
    input wire logic     active_mode,
    input wire logic     cmd_warning
);
    // ----------------------------------------
    // Link assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    servo_off_ends_a: assert property (active_mode && !servo_on |=> !active_mode)
        else $error("active mode kept after servo off");
    motion_quiet_a: assert property (active_mode && $past(active_mode, 2) && cmd_valid
        |-> cmd inside {CMD_NOP, CMD_HOLD, CMD_STATUS_MONITOR_COMMAND}) else $error("motion command in active mode");
    warn_cause_a: assert property (cmd_warning |-> $past(cmd_valid && cmd == CMD_CONFIG && servo_on))
        else $error("warning without config under servo on");
    warn_keeps_a: assert property (cmd_warning && $past(active_mode) |-> active_mode)
        else $error("refused config ended active mode");
    config_ends_a: assert property (cmd_valid && cmd == CMD_CONFIG && active_mode
        |=> !active_mode || cmd_warning) else $error("config kept active mode");
    target_position_drop_a: assert property ($rose(active_mode) && target_position_valid |-> ##[1:4] !target_position_valid)
        else $error("target position kept live");
    cancel_pulse_a: assert property (cancel |-> active_mode ##1 !cancel)
        else $error("cancel outside active mode");
    resume_after_a: assert property ($rose(target_position_valid) |-> !active_mode && !$past(active_mode))
        else $error("motion resumed in active mode");
endmodule

// file: bench/active_mode_return_control_tb.sv
// Testbench joining host and drive ends over the command link.
// Assumes a 20 MHz clock and 4 cycles per hold time unit.
`timescale 1ns/1ns
module active_mode_return_control_tb;
    import amr_pkg::*;
    logic        ref_clk, reset_n, safety_req, ot, stopped, zc_req, act_en;
    logic        pos_mode, pe_ok, sr_ok, sys_rst, recalc, son_req, ucv;
    logic        act, int_dec, ot_dec, srv_rst, rc_done, zclamp, taken, standby, warn_seen;
    logic [15:0] hold;
    amr_ref_t    path;
    amr_cmd_t    ucmd;
    int          errors, checks_done, n;
    logic        g;
    amr_cmd_t    pcmd [5] = '{CMD_POSITIONING_COMMAND, CMD_FEED, CMD_EXPOS, CMD_HOMING, CMD_EXFEED};
    amr_link_if link ();
    amr_device #(.CYC_PER_UNIT(4), .HOLD_W(16)) u_amr_device (.REF_CLK(ref_clk), .RESET_N(reset_n),
        .LINK(link), .SAFETY_REQ(safety_req), .OVERTRAVEL(ot), .MOTOR_STOPPED(stopped),
        .ZERO_CLAMP_REQ(zc_req), .ACTIVE_ENABLE(act_en), .REF_PATH(path), .POS_MODE(pos_mode),
        .POS_ERR_OK(pe_ok), .SPEED_REF_OK(sr_ok), .HOLD_TIME(hold), .SYS_RESET_REQ(sys_rst),
        .PARAM_RECALC(recalc), .ACTIVE_MODE(act), .INTERNAL_DECEL(int_dec), .OT_DECEL(ot_dec),
        .SERVO_RESTART(srv_rst), .RECALC_DONE(rc_done), .ZERO_CLAMP(zclamp));
    amr_host u_amr_host (.REF_CLK(ref_clk), .RESET_N(reset_n), .LINK(link), .REF_PATH(path),
        .POS_MODE(pos_mode), .SERVO_ON_REQ(son_req), .USER_CMD_VALID(ucv), .USER_CMD(ucmd),
        .USER_CMD_TAKEN(taken), .STANDBY(standby), .WARNING_SEEN(warn_seen));
    amr_link_properties u_amr_link_properties (.REF_CLK(ref_clk), .RESET_N(reset_n),
        .cmd_valid(link.cmd_valid), .cmd(link.cmd), .cancel(link.cancel), .target_position_valid(link.target_position_valid),
        .servo_on(link.servo_on), .active_mode(link.active_mode), .cmd_warning(link.cmd_warning));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // Bounded so a stuck indicator cannot hang the run
    task automatic wait_act(input logic lvl, output int c);
        c = 0;
        while (act !== lvl && c < 60) begin
            tick(1);
            c++;
        end
    endtask
    task automatic seen(ref logic s, output logic got);
        got = (s === 1'b1);
        repeat (4) begin
            tick(1);
            got |= (s === 1'b1);
        end
    endtask
    task automatic send(input amr_cmd_t c);
        int k;
        k = 0;
        ucmd = c;
        ucv = 1'b1;
        while (taken !== 1'b1 && k < 8) begin
            tick(1);
            k++;
        end
        ucv = 1'b0;
    endtask
    task automatic enter();
        safety_req = 1'b0;
        wait_act(1'b1, n);
        check(act, 1'b1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_react(input amr_ref_t p, input logic pm, input amr_cmd_t c, input amr_cmd_t ec, input logic cn);
        path = p;
        pos_mode = pm;
        send(c);
        tick(2);
        enter();
        g = 1'b0;
        repeat (8) begin
            tick(1);
            if (cn ? link.cancel === 1'b1 : (link.cmd_valid === 1'b1 && link.cmd === ec))
                g = 1'b1;
        end
        check(g, 1'b1);
        check(standby, 1'b1);
        check(link.target_position_valid, 1'b0);
        safety_req = 1'b1;
        wait_act(1'b0, n);
        tick(2);
        check(standby, 1'b0);
    endtask
    task automatic t_release();
        hold = 16'h0002;
        for (int m = 0; m < 2; m++) begin
            pos_mode = m[0];
            pe_ok = ~m[0];
            sr_ok = m[0];
            enter();
            safety_req = 1'b1;
            tick(30);
            check(act, 1'b1);
            pe_ok = 1'b1;
            sr_ok = 1'b1;
            wait_act(1'b0, n);
            check(n < 4, 1'b1);
        end
        enter();
        safety_req = 1'b1;
        wait_act(1'b0, n);
        check(n >= 8 && n <= 24, 1'b1);
        hold = 16'h0001;
    endtask
    task automatic t_ot();
        enter();
        check(int_dec, 1'b1);
        ot = 1'b1;
        tick(4);
        check({int_dec, ot_dec}, 2'b01);
        safety_req = 1'b1;
        tick(20);
        check(act, 1'b1);
        stopped = 1'b1;
        tick(4);
        check({act, ot_dec}, 2'b10);
        wait_act(1'b0, n);
        check(act, 1'b0);
        check(n > 3, 1'b1);
        ot = 1'b0;
        stopped = 1'b0;
        tick(4);
    endtask
    task automatic t_exits();
        path = REF_BUS_OLD;
        enter();
        sys_rst = 1'b1;
        seen(srv_rst, g);
        sys_rst = 1'b0;
        check({g, act}, 2'b10);
        enter();
        recalc = 1'b1;
        tick(1);
        recalc = 1'b0;
        // Safety request is still low, so the mode comes straight back a cycle later
        check({rc_done, act}, 2'b10);
        enter();
        son_req = 1'b0;
        safety_req = 1'b1;
        tick(4);
        check(act, 1'b0);
        son_req = 1'b1;
        tick(6);
        send(CMD_CONFIG);
        seen(rc_done, g);
        check({g, warn_seen}, 2'b10);
        path = REF_BUS_NEW;
        send(CMD_CONFIG);
        seen(rc_done, g);
        check({g, warn_seen}, 2'b01);
    endtask
    // Config leaves the host on the entry edge, so the drive sees it in active mode
    task automatic t_cfg_active(input amr_ref_t p, input logic [2:0] exp);
        path = p;
        safety_req = 1'b0;
        tick(2);
        send(CMD_CONFIG);
        tick(1);
        check({act, link.cmd_warning, rc_done}, exp);
        safety_req = 1'b1;
        tick(2);
        wait_act(1'b0, n);
        tick(2);
    endtask
    task automatic t_zc();
        path = REF_ANALOG;
        zc_req = 1'b1;
        tick(5);
        check(zclamp, 1'b1);
        enter();
        tick(2);
        check(zclamp, 1'b0);
        safety_req = 1'b1;
        wait_act(1'b0, n);
        zc_req = 1'b0;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #2_000_000;
        errors++;
        give_verdict();
    end
    initial begin
        {reset_n, ot, stopped, zc_req, sys_rst, recalc, ucv} = '0;
        {safety_req, act_en, son_req, pe_ok, sr_ok, pos_mode} = 6'b111110;
        path = REF_BUS_OLD;
        hold = 16'h0001;
        ucmd = CMD_NOP;
        errors = 0;
        checks_done = 0;
        tick(16);
        reset_n = 1'b1;
        tick(4);
        t_react(REF_BUS_OLD, 1'b0, CMD_VELOCITY_CONTROL_COMMAND, CMD_HOLD, 1'b0);
        t_react(REF_BUS_NEW, 1'b0, CMD_VELOCITY_CONTROL_COMMAND, CMD_NOP, 1'b1);
        t_react(REF_BUS_OLD, 1'b1, CMD_INTERP, CMD_NOP, 1'b0);
        t_react(REF_BUS_NEW, 1'b1, CMD_INTERP, CMD_NOP, 1'b0);
        foreach (pcmd[i]) begin
            if (i < 4)
                t_react(REF_BUS_OLD, 1'b1, pcmd[i], CMD_HOLD, 1'b0);
            t_react(REF_BUS_NEW, 1'b1, pcmd[i], CMD_NOP, 1'b1);
        end
        t_release();
        t_ot();
        t_exits();
        t_cfg_active(REF_BUS_NEW, 3'b110);
        t_cfg_active(REF_BUS_OLD, 3'b001);
        t_zc();
        give_verdict();
    end
endmodule
